/* emb_map.svh */
// Address map, phase timing and reset constants for the external memory bus cycle block
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH
`define EMB_INT_LO 16'h8000
`define EMB_INT_HI 16'h8fff
`define EMB_EXT_LO 16'h9000
`define EMB_EXT_HI 16'h7fff
`define EMB_BOOT_ADDR 16'h7ffe
`define EMB_SAVE_LO 16'h8016
`define EMB_SAVE_HI 16'h8022
`define EMB_CLKIN_NS 125
`define EMB_CLK_NS 10
`define EMB_MULT 4
`define EMB_PHASE_CYC ((`EMB_CLKIN_NS / `EMB_MULT) / (2 * `EMB_CLK_NS))
`define EMB_ADDR_RST 16'h0000
`endif

/* emb_pkg.sv */
// Types for the external memory bus cycle block
package emb_pkg;
    typedef enum logic [2:0] {
        EMB_IDLE = 3'b000,
        EMB_P1 = 3'b001,
        EMB_P2 = 3'b011,
        EMB_WA = 3'b010,
        EMB_WB = 3'b110,
        EMB_P3 = 3'b111,
        EMB_P4 = 3'b101
    } emb_phase_t;
endpackage

/* emb_bus_cycle.sv */
// External static memory bus cycle generator
//=====================================================
// Notes on behaviour
// RL1: Addresses 9000 upward wrapping to 7fff go to the external bus.
// RL2: ROM boot fetch starts at external address 7ffe.
// RL3: Pre-emption save words 8016..8022 are on-chip; flagged when accessed.
// RL4: 16-bit address and data buses; word and byte-wide access mixable.
// RL5: Processor clock period is input clock period over the multiplier.
// RL6: All strobe edges are timed from processor clock edges.
// RL7: Cycle phases run one, two, three, four in order.
// RL8: Each phase is half a processor clock; unextended cycle is two clocks.
// RL9: Cycles are whole clocks; phase one starts on a rising clock edge.
// RL10: Wait requests stretch phase two by whole clocks, without limit.
// RL11: On-chip access shows the word address, strobes idle, data tristated.
// RL12: During DMA all memory lines are released to high impedance.
// RL13: Address is valid from phase one start to phase four end.
// RL14: Reads fetch a whole word; writes select bytes only by strobes.
// RL15: Read data is sampled in phase four; memory removes it by then.
// RL16: Write data is driven from phase two start until phase four end.
// RL17: Memory captures write data on the rising edge of the select.
// RL18: Data bus floats except when writing; unused byte lane floats.
// RL19: Byte mode second cycle keeps the upper lane floating.
// RL20: Addresses 8000..8fff are on-chip memory.
// RL21: Word write asserts both strobes; byte write only the addressed lane.
// RL22: Byte mode accesses low byte at even address, then high at plus one.
// RL23: A wait state is wait phase a then wait phase b between two and three.
// RL24: Byte reads select the low byte if address bit zero clear, else high.
`timescale 1ns/1ps
`default_nettype none
`include "emb_map.svh"
module emb_bus_cycle
    import emb_pkg::*;
#(
    parameter int PHASE_CYC = `EMB_PHASE_CYC
)(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Core request side
    input wire logic req_in,
    input wire logic [15:0] req_addr_in,
    input wire logic req_write_in,
    input wire logic req_byte_in,
    input wire logic [15:0] req_wdata_in,
    input wire logic boot_fetch_in,
    output logic busy_out,
    output logic done_out,
    output logic [15:0] rdata_out,
    output logic save_slot_out,
    // Pins from outside
    input wire logic mem_wait_in,
    input wire logic byte_access_select_in,
    input wire logic dma_request_in,
    input wire logic [15:0] external_data_bus_in,
    // Pins to memory
    output logic processor_clock_output_out,
    output logic [15:0] external_address_bus_out,
    output logic external_address_bus_oe_n_out,
    output logic [15:0] external_data_bus_out,
    output logic [1:0] external_data_bus_oe_n_out,
    output logic [1:0] byte_write_strobes_n_out,
    output logic memory_select_n_out,
    output logic control_oe_n_out
);
    //=====================================================
    // Input synchronisers
    logic [2:0] wait_sync_reg;
    logic [2:0] bacc_sync_reg;
    logic [2:0] dma_sync_reg;
    logic wait_q_reg;
    logic bacc_q_reg;
    logic dma_q_reg;
    always_ff @(posedge clk_in)
    begin
        wait_sync_reg <= {wait_sync_reg[1:0], mem_wait_in};
        bacc_sync_reg <= {bacc_sync_reg[1:0], byte_access_select_in};
        dma_sync_reg <= {dma_sync_reg[1:0], dma_request_in};
        if (reset_in)
        begin
            wait_q_reg <= 1'b0;
            bacc_q_reg <= 1'b0;
            dma_q_reg <= 1'b0;
        end
        else
        begin
            if (wait_sync_reg[1] == wait_sync_reg[2])
                wait_q_reg <= wait_sync_reg[2];
            if (bacc_sync_reg[1] == bacc_sync_reg[2])
                bacc_q_reg <= bacc_sync_reg[2];
            if (dma_sync_reg[1] == dma_sync_reg[2])
                dma_q_reg <= dma_sync_reg[2];
        end
    end

    //=====================================================
    // Half-period divider for the processor clock
    // Period = input clock period / multiplier, split in two phases
    logic [7:0] div_reg;
    logic pclk_reg;
    wire half_tick = (div_reg == 8'(PHASE_CYC - 1));
    wire rise_tick = half_tick && !pclk_reg;
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            div_reg <= 8'h00;
            pclk_reg <= 1'b0;
        end
        else if (half_tick)
        begin
            div_reg <= 8'h00;
            pclk_reg <= !pclk_reg; // RL5
        end
        else
            div_reg <= div_reg + 8'h01;
    end

    //=====================================================
    // Address decode
    // Decode the forced boot address too, so a boot fetch always leaves the chip
    wire [15:0] eff_addr = boot_fetch_in ? `EMB_BOOT_ADDR : req_addr_in; // RL2
    wire on_chip = (eff_addr >= `EMB_INT_LO) && (eff_addr <= `EMB_INT_HI); // RL20
    wire ext_space = !on_chip; // RL1
    wire in_save = (eff_addr >= `EMB_SAVE_LO) && (eff_addr <= `EMB_SAVE_HI); // RL3
    wire [15:0] word_addr = {eff_addr[15:1], 1'b0};

    //=====================================================
    // Phase sequencer
    emb_phase_t phase_reg, phase_next;
    logic write_reg;
    logic byte_reg;
    logic lane_reg;
    logic second_reg;
    logic bmode_reg;
    logic [15:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rbuf_reg;
    wire last_cycle = !bmode_reg || second_reg;
    wire start_ok = req_in && !busy_out && !dma_q_reg && rise_tick;
    always_comb
    begin
        phase_next = phase_reg;
        if (half_tick)
        begin
            unique case (phase_reg)
                EMB_IDLE: phase_next = (start_ok && ext_space) ? EMB_P1 : EMB_IDLE; // RL9
                EMB_P1: phase_next = EMB_P2; // RL7
                EMB_P2: phase_next = wait_q_reg ? EMB_WA : EMB_P3; // RL10
                EMB_WA: phase_next = EMB_WB; // RL23
                EMB_WB: phase_next = wait_q_reg ? EMB_WA : EMB_P3; // RL23
                EMB_P3: phase_next = EMB_P4; // RL7
                EMB_P4: phase_next = last_cycle ? EMB_IDLE : EMB_P1; // RL22
                default: phase_next = EMB_IDLE;
            endcase
        end
    end

    wire cycle_end = half_tick && (phase_reg == EMB_P4);
    wire int_start = start_ok && on_chip && (phase_reg == EMB_IDLE);
    wire ext_start = half_tick && start_ok && ext_space && (phase_reg == EMB_IDLE);
    // RL14 RL24: whole word fetched, byte picked internally
    wire [15:0] rd_word = second_reg ? {external_data_bus_in[7:0], rbuf_reg[7:0]} : external_data_bus_in;
    wire [15:0] rd_pick = byte_reg ? {8'h00, (lane_reg ? rd_word[15:8] : rd_word[7:0])} : rd_word;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            phase_reg <= EMB_IDLE;
            write_reg <= 1'b0;
            byte_reg <= 1'b0;
            lane_reg <= 1'b0;
            second_reg <= 1'b0;
            bmode_reg <= 1'b0;
            addr_reg <= `EMB_ADDR_RST;
            wdata_reg <= 16'h0000;
            rbuf_reg <= 16'h0000;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= 16'h0000;
            save_slot_out <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            done_out <= 1'b0;
            if (int_start)
            begin
                addr_reg <= word_addr; // RL11
                save_slot_out <= in_save; // RL3
                done_out <= 1'b1;
            end
            if (ext_start)
            begin
                addr_reg <= word_addr; // RL13
                write_reg <= req_write_in;
                byte_reg <= req_byte_in;
                lane_reg <= eff_addr[0];
                wdata_reg <= req_wdata_in;
                second_reg <= 1'b0;
                bmode_reg <= 1'b0;
                save_slot_out <= 1'b0;
                busy_out <= 1'b1;
            end
            // Byte-wide mode is latched in phase two
            if (half_tick && phase_reg == EMB_P2 && !second_reg)
                bmode_reg <= bacc_q_reg; // RL4
            // Read data sampled at the end of phase four
            if (cycle_end)
            begin
                if (!write_reg)
                    rbuf_reg <= external_data_bus_in; // RL15
                if (last_cycle)
                begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                    if (!write_reg)
                        rdata_out <= rd_pick; // RL24
                end
                else
                begin
                    second_reg <= 1'b1;
                    addr_reg <= {addr_reg[15:1], 1'b1}; // RL22
                end
            end
        end
    end

    //=====================================================
    // Pin drive
    wire in_cycle = (phase_reg != EMB_IDLE);
    wire data_phase = in_cycle && (phase_reg != EMB_P1);
    wire sel_phase = (phase_reg == EMB_P2) || (phase_reg == EMB_WA) || (phase_reg == EMB_WB) || (phase_reg == EMB_P3);
    // Low lane enabled for word or low byte; in a second byte-mode cycle only for word or high byte
    wire lane0_w = !byte_reg || !lane_reg || second_reg;
    wire lane1_w = !second_reg && (!byte_reg || lane_reg);
    wire lane0_act = second_reg ? (!byte_reg || lane_reg) : lane0_w;
    wire drive_wr = write_reg && data_phase; // RL16
    wire [15:0] wr_bus = second_reg ? {8'h00, wdata_reg[15:8]} : wdata_reg;
    // Strobes set up before the select falls, so they already open in phase one
    wire [1:0] strobe_n = (write_reg && in_cycle && phase_reg != EMB_P4) ?
        ~{lane1_w, lane0_act} : 2'b11; // RL21 RL14
    wire sel_n = !(in_cycle && sel_phase); // RL6

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            processor_clock_output_out <= 1'b0;
            external_address_bus_out <= `EMB_ADDR_RST;
            external_address_bus_oe_n_out <= 1'b0;
            external_data_bus_out <= 16'h0000;
            external_data_bus_oe_n_out <= 2'b11;
            byte_write_strobes_n_out <= 2'b11;
            memory_select_n_out <= 1'b1;
            control_oe_n_out <= 1'b0;
        end
        else
        begin
            processor_clock_output_out <= pclk_reg;
            external_address_bus_out <= (int_start || ext_start) ? word_addr : addr_reg;
            external_address_bus_oe_n_out <= dma_q_reg; // RL12
            control_oe_n_out <= dma_q_reg; // RL12
            external_data_bus_out <= wr_bus;
            // RL18 RL19: upper lane floats in the second byte-mode cycle
            external_data_bus_oe_n_out <= (drive_wr && !dma_q_reg) ? ~{lane1_w, lane0_act} : 2'b11;
            byte_write_strobes_n_out <= strobe_n; // RL11
            memory_select_n_out <= sel_n; // RL17
        end
    end

    //=====================================================
    // Checks
    cycle_order_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL7
        (phase_reg == EMB_P1 && phase_next != EMB_P1) |-> phase_next == EMB_P2)
        else $error("phase one not followed by phase two");
    start_rise_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL9
        (phase_reg == EMB_IDLE && phase_next == EMB_P1) |-> !pclk_reg)
        else $error("cycle did not start on rising clock");
    wait_after_two_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL23
        (phase_reg == EMB_WA && half_tick) |=> phase_reg == EMB_WB)
        else $error("wait phase a not followed by b");
    addr_hold_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL13
        (in_cycle && $past(in_cycle) && !$past(cycle_end)) |-> $stable(addr_reg))
        else $error("address changed inside cycle");
    byte_second_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL19
        (second_reg && in_cycle) |=> external_data_bus_oe_n_out[1])
        else $error("upper lane driven in second byte cycle");
    read_float_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL18
        (!write_reg || !in_cycle) |=> external_data_bus_oe_n_out == 2'b11)
        else $error("data bus driven while not writing");
    dma_release_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL12
        dma_q_reg |=> external_address_bus_oe_n_out && control_oe_n_out)
        else $error("lines not released during dma");
    int_idle_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL11
        int_start |=> memory_select_n_out)
        else $error("select active on internal access");
    word_strobes_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL21
        (write_reg && !byte_reg && !second_reg && phase_reg == EMB_P2) |-> strobe_n == 2'b00)
        else $error("word write strobes wrong");
    // Pin checks look one clock later: every pin is registered, one clock behind the state it is decoded from
    sel_idle_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL11
        !in_cycle |=> memory_select_n_out)
        else $error("select active outside a cycle");
    strobe_idle_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL11
        !in_cycle |=> byte_write_strobes_n_out == 2'b11)
        else $error("write strobes active outside a cycle");
    addr_pin_hold_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL13
        (in_cycle && $past(in_cycle) && !$past(cycle_end)) |=> $stable(external_address_bus_out))
        else $error("address pins changed inside cycle");
    end_rise_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL9
        cycle_end |-> !pclk_reg)
        else $error("cycle did not end on a whole clock");
    byte_strobe_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL21
        (write_reg && byte_reg && !second_reg && phase_reg == EMB_P2) |-> (strobe_n == 2'b01 || strobe_n == 2'b10))
        else $error("byte write strobes wrong");
    lane_float_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL18
        (write_reg && byte_reg && !second_reg && data_phase && !dma_q_reg) |=> external_data_bus_oe_n_out != 2'b00)
        else $error("unused lane driven on byte write");
    word_drive_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL16
        (write_reg && !byte_reg && !second_reg && data_phase && !dma_q_reg) |=> external_data_bus_oe_n_out == 2'b00)
        else $error("word write data not driven");
    phase_one_float_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL16
        (phase_reg == EMB_P1) |=> external_data_bus_oe_n_out == 2'b11)
        else $error("data driven in phase one");
    done_end_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL15
        (cycle_end && last_cycle) |=> done_out && !busy_out)
        else $error("completion missing after phase four");
    wait_stretch_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL10
        (half_tick && phase_reg == EMB_P2 && wait_q_reg) |=> phase_reg == EMB_WA)
        else $error("wait request not honoured");
    no_wait_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL7
        (half_tick && phase_reg == EMB_P2 && !wait_q_reg) |=> phase_reg == EMB_P3)
        else $error("phase two not followed by phase three");
    byte_pair_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL22
        (cycle_end && !last_cycle) |=> (phase_reg == EMB_P1 && addr_reg[0]))
        else $error("second byte cycle not at odd address");
    dma_float_a: assert property (@(posedge clk_in) disable iff (reset_in) // RL12
        dma_q_reg |=> external_data_bus_oe_n_out == 2'b11)
        else $error("data bus driven during dma");
endmodule
`default_nettype wire

/* emb_mem_model.sv */
// Behavioural static memory on the far side of the bus cycle block
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Bus from the block
    input wire logic [15:0] addr_in,
    input wire logic [15:0] data_in,
    input wire logic [1:0] strobe_n_in,
    input wire logic select_n_in,
    input wire logic [7:0] wait_len_in,
    // Answers to the block
    output logic [15:0] data_out,
    output logic wait_out
);
    logic [7:0] mem [int];
    logic sel_q;
    logic [1:0] stb_acc;
    logic [7:0] cnt;
    function automatic logic [7:0] rd(input int a);
        return mem.exists(a) ? mem[a] : 8'h00;
    endfunction
    // Armed while idle so the block sees the request before it samples
    assign wait_out = cnt < wait_len_in;
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sel_q <= 1'b1;
            stb_acc <= 2'b11;
            cnt <= 8'h00;
            data_out <= 16'h5a5a;
        end
        else
        begin
            sel_q <= select_n_in;
            cnt <= select_n_in ? 8'h00 : cnt + 8'h01;
            stb_acc <= select_n_in ? 2'b11 : stb_acc & strobe_n_in;
            if (select_n_in && !sel_q && !stb_acc[0])
                mem[addr_in] = data_in[7:0];
            if (select_n_in && !sel_q && !stb_acc[1])
                mem[addr_in | 1] = data_in[15:8];
            // Released lines show the inverse so a stale value never passes
            data_out <= (!select_n_in && &strobe_n_in) ? {rd(addr_in | 1), rd(addr_in)} : ~data_out;
        end
    end
endmodule
`default_nettype wire

/* emb_bus_cycle_bench.sv */
// Self-checking bench for the external memory bus cycle block
`timescale 1ns/1ps
`default_nettype none
module emb_bus_cycle_bench;
    import emb_pkg::*;
    localparam int PC = 2;
    logic clk_in, reset_in, req_in, req_write_in, req_byte_in, boot_fetch_in, bmode, dma;
    logic [15:0] req_addr_in, req_wdata_in, d_addr, d_dout, m_dq, dbus, q, d, a, fall_addr;
    logic [1:0] d_doe_n, d_stb, stb;
    logic busy_out, done_out, save_slot_out, pco, a_oe_n, d_sel, c_oe_n, sel, m_wait, sel_q;
    logic [15:0] rdata_out;
    logic [7:0] wait_len;
    logic [7:0] rm [int];
    logic [15:0] addrs [8];
    logic [15:0] seed;
    int failures, checked, falls, low_cnt, last_len, len0, f0, n, i;
    time t0;
    // Pull-ups on the control lines, per-lane choice of driver on data
    assign stb = c_oe_n ? 2'b11 : d_stb;
    assign sel = c_oe_n ? 1'b1 : d_sel;
    assign dbus = {d_doe_n[1] ? m_dq[15:8] : d_dout[15:8], d_doe_n[0] ? m_dq[7:0] : d_dout[7:0]};
    emb_bus_cycle #(.PHASE_CYC(PC)) i_emb_bus_cycle (.clk_in(clk_in), .reset_in(reset_in),
        .req_in(req_in), .req_addr_in(req_addr_in), .req_write_in(req_write_in), .req_byte_in(req_byte_in),
        .req_wdata_in(req_wdata_in), .boot_fetch_in(boot_fetch_in), .busy_out(busy_out), .done_out(done_out),
        .rdata_out(rdata_out), .save_slot_out(save_slot_out), .mem_wait_in(m_wait),
        .byte_access_select_in(bmode), .dma_request_in(dma), .external_data_bus_in(dbus),
        .processor_clock_output_out(pco), .external_address_bus_out(d_addr),
        .external_address_bus_oe_n_out(a_oe_n), .external_data_bus_out(d_dout),
        .external_data_bus_oe_n_out(d_doe_n), .byte_write_strobes_n_out(d_stb),
        .memory_select_n_out(d_sel), .control_oe_n_out(c_oe_n));
    emb_mem_model i_emb_mem_model (.clk_in(clk_in), .reset_in(reset_in), .addr_in(d_addr), .data_in(dbus),
        .strobe_n_in(stb), .select_n_in(sel), .wait_len_in(wait_len), .data_out(m_dq), .wait_out(m_wait));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] rb(input int k);
        return rm.exists(k) ? rm[k] : 8'h00;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic mref(input logic b, input logic [15:0] k, input logic [15:0] v);
        if (!b)
        begin
            rm[k & 16'hfffe] = v[7:0];
            rm[k | 1] = v[15:8];
        end
        else
            rm[k] = k[0] ? v[15:8] : v[7:0];
    endtask
    // Request held until the completion pulse, released at the next falling edge
    task automatic op(input logic w, input logic b, input logic bt, input logic [15:0] k, input logic [15:0] v);
        @(negedge clk_in);
        {req_in, req_write_in, req_byte_in, boot_fetch_in, req_addr_in, req_wdata_in} = {1'b1, w, b, bt, k, v};
        n = 0;
        do
        begin
            @(negedge clk_in);
            n++;
        end
        while (done_out !== 1'b1 && n < 300);
        q = rdata_out;
        req_in = 1'b0;
        boot_fetch_in = 1'b0;
        if (n >= 300)
            check(16'hdead, 16'h0);
    endtask
    // Bus watcher on the settled side of the clock
    always @(negedge clk_in)
    begin
        sel_q <= sel;
        if (!sel && sel_q)
        begin
            falls <= falls + 1;
            fall_addr <= d_addr;
            low_cnt <= 1;
        end
        else if (!sel)
        begin
            low_cnt <= low_cnt + 1;
            check(d_addr, fall_addr);
            check({15'h0, busy_out}, 16'h1);
            if (bmode && d_addr[0])
                check({15'h0, d_doe_n[1]}, 16'h1);
            if (stb == 2'b00)
                check({14'h0, d_doe_n}, 16'h0);
            if (stb == 2'b11)
                check({14'h0, d_doe_n}, 16'h3);
        end
        else if (!sel_q)
            last_len <= low_cnt;
    end
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial
    begin
        #200000;
        failures++;
        give_verdict();
    end
    initial
    begin
        {reset_in, req_in, req_write_in, req_byte_in, boot_fetch_in, bmode, dma} = 7'b1000000;
        {req_addr_in, req_wdata_in, wait_len, seed} = {32'h0, 8'h0, 16'h001f};
        repeat (10) @(negedge clk_in);
        check({12'h0, sel, d_stb, d_doe_n[0]}, 16'hf);
        reset_in = 1'b0;
        @(posedge pco);
        t0 = $time;
        @(posedge pco);
        check(16'(($time - t0) / 10), 16'(2 * PC));
        for (i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            a = (i[0] ? 16'h9000 : 16'h7000) + (seed & 16'h0ffe) + {15'h0, i[1] & seed[15]};
            d = lfsr(seed ^ 16'h1234);
            addrs[i] = a;
            op(1'b1, i[1], 1'b0, a, d);
            mref(i[1], a, d);
        end
        for (i = 0; i < 8; i++)
        begin
            op(1'b0, 1'b0, 1'b0, addrs[i] & 16'hfffe, 16'h0);
            check(q, {rb(addrs[i] | 1), rb(addrs[i] & 16'hfffe)});
            op(1'b0, 1'b1, 1'b0, addrs[i], 16'h0);
            check(q, {8'h00, rb(addrs[i])});
        end
        op(1'b0, 1'b0, 1'b0, 16'h9100, 16'h0);
        len0 = last_len;
        wait_len = 8'd9;
        op(1'b0, 1'b0, 1'b0, 16'h9100, 16'h0);
        wait_len = 8'd0;
        check(16'(last_len > len0), 16'h1);
        check(16'((last_len - len0) % (2 * PC)), 16'h0);
        bmode = 1'b1;
        repeat (6) @(negedge clk_in);
        f0 = falls;
        op(1'b1, 1'b0, 1'b0, 16'h9200, 16'hc3a5);
        mref(1'b0, 16'h9200, 16'hc3a5);
        check(16'(falls - f0), 16'h2);
        op(1'b0, 1'b0, 1'b0, 16'h9200, 16'h0);
        check(q, {rb(16'h9201), rb(16'h9200)});
        bmode = 1'b0;
        repeat (6) @(negedge clk_in);
        op(1'b0, 1'b0, 1'b0, 16'h9200, 16'h0);
        check(q, 16'hc3a5);
        f0 = falls;
        op(1'b1, 1'b0, 1'b0, 16'h8016, 16'hbeef);
        check({15'h0, save_slot_out}, 16'h1);
        op(1'b0, 1'b0, 1'b0, 16'h8024, 16'h0);
        check({15'h0, save_slot_out}, 16'h0);
        check(d_addr, 16'h8024);
        check({16'(falls - f0)}, 16'h0);
        check({13'h0, d_stb, d_doe_n[0]}, 16'h7);
        op(1'b1, 1'b0, 1'b0, 16'h7ffe, 16'h5e71);
        mref(1'b0, 16'h7ffe, 16'h5e71);
        op(1'b0, 1'b0, 1'b1, 16'h9300, 16'h0);
        check(fall_addr, 16'h7ffe);
        check(q, {rb(16'h7fff), rb(16'h7ffe)});
        dma = 1'b1;
        repeat (8) @(negedge clk_in);
        check({13'h0, a_oe_n, c_oe_n, &d_doe_n}, 16'h7);
        dma = 1'b0;
        repeat (8) @(negedge clk_in);
        give_verdict();
    end
endmodule
`default_nettype wire
